// ---- hw/prvd_cfg.svh ----
// Constants for the receive deframer: pin indices, slot counts, reset values
`ifndef PRVD_CFG_SVH
`define PRVD_CFG_SVH

// Index of each pin in the synchroniser vector
`define PRVD_PIN_MCLK   0
`define PRVD_PIN_FSYNC  1
`define PRVD_PIN_DATA   2
`define PRVD_PIN_LIN    3
`define PRVD_PIN_MUTE   4
`define PRVD_PIN_COUNT  5

// Frame layout
`define PRVD_SLOT_FIRST 5'h01
`define PRVD_SLOT_PRE   5'h0f
`define PRVD_SLOT_LAST  5'h10
`define PRVD_MCLK_PER_FRAME 256

// Gain decode: code 0 is +3 dB, 3 dB per step
`define PRVD_GAIN_TOP   6'h03
`define PRVD_GAIN_0DB   6'h00
`define PRVD_GAIN_RESET 3'h1

`endif

// ---- hw/prvd_pkg.sv ----
// Types shared by the receive deframer
package prvd_pkg;
   typedef enum logic [1:0] {
      PRVD_IDLE     = 2'b00,
      PRVD_SHIFT    = 2'b01,
      PRVD_WAIT_LOW = 2'b11
   } prvd_state_t;

   typedef logic [12:0]        prvd_sample_t;
   typedef logic [2:0]         prvd_gain_code_t;
   typedef logic signed [5:0]  prvd_gain_db_t;
endpackage

// ---- hw/prvd_rx_deframer.sv ----
// Receive serial sample deframer with gain decode, mute and two-entry output buffer
`timescale 1ns/100ps
`default_nettype none
`include "prvd_cfg.svh"

module prvd_rx_deframer (
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire logic               master_clock,
   input  wire logic               frame_sync,
   input  wire logic               serial_rx_data_in,
   input  wire logic               linear_select,
   input  wire logic               earpiece_silence,
   input  wire logic               out_ready,
   output logic                    out_valid,
   output prvd_pkg::prvd_sample_t  out_sample,
   output logic                    out_linear,
   output prvd_pkg::prvd_gain_db_t out_gain_db,
   output prvd_pkg::prvd_gain_code_t rx_gain_code,
   output logic                    overrun
);
   import prvd_pkg::*;

   function automatic prvd_gain_db_t gain_db_f(input prvd_gain_code_t code);
      logic [5:0] c6;
      c6 = {3'h0, code};
      return prvd_gain_db_t'(`PRVD_GAIN_TOP - (c6 + c6 + c6));
   endfunction

   logic [`PRVD_PIN_COUNT-1:0] pin_raw;
   logic [`PRVD_PIN_COUNT-1:0] sync1_reg;
   logic [`PRVD_PIN_COUNT-1:0] sync2_reg;
   logic [`PRVD_PIN_COUNT-1:0] sync3_reg;
   logic [`PRVD_PIN_COUNT-1:0] lvl_reg;
   logic [`PRVD_PIN_COUNT-1:0] lvl_next;
   logic                       mclk_fall;
   logic                       fsync_now;
   logic                       data_now;
   prvd_state_t                state_reg;
   logic [4:0]                 slot_reg;
   logic [15:0]                shift_reg;
   logic                       frm_lin_reg;
   logic                       done_reg;
   prvd_gain_code_t            gain_code_reg;
   prvd_sample_t               new_sample;
   prvd_gain_db_t              new_gain_db;
   logic                       pop;
   logic                       out_valid_reg;
   prvd_sample_t               out_sample_reg;
   logic                       out_linear_reg;
   prvd_gain_db_t              out_gain_db_reg;
   logic                       skid_valid_reg;
   prvd_sample_t               skid_sample_reg;
   logic                       skid_linear_reg;
   prvd_gain_db_t              skid_gain_db_reg;
   logic                       overrun_reg;

   assign pin_raw = {earpiece_silence, linear_select, serial_rx_data_in, frame_sync,
                     master_clock};

   // Three stages; a level counts only once stages two and three agree
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
         lvl_reg   <= '0;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         lvl_reg   <= lvl_next;
      end
   end

   assign lvl_next  = (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (lvl_reg & (sync2_reg ^ sync3_reg));
   // Every slot step hangs off the filtered master clock edge
   assign mclk_fall = lvl_reg[`PRVD_PIN_MCLK] & ~lvl_next[`PRVD_PIN_MCLK];
   // Sync and data pass the same chain, so they stay aligned to the clock edge
   assign fsync_now = lvl_next[`PRVD_PIN_FSYNC];
   assign data_now  = lvl_next[`PRVD_PIN_DATA];

   // Slot counter and frame state
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg   <= PRVD_IDLE;
         slot_reg    <= 5'h00;
         shift_reg   <= 16'h0000;
         frm_lin_reg <= 1'b0;
         done_reg    <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (mclk_fall) begin
            unique case (state_reg)
               PRVD_IDLE: begin
                  if (fsync_now) begin
                     state_reg   <= PRVD_SHIFT;
                     slot_reg    <= `PRVD_SLOT_FIRST;
                     shift_reg   <= {15'h0000, data_now};
                     frm_lin_reg <= ~lvl_next[`PRVD_PIN_LIN];
                  end
               end
               PRVD_SHIFT: begin
                  shift_reg <= {shift_reg[14:0], data_now};
                  slot_reg  <= slot_reg + 5'h01;
                  if (slot_reg == `PRVD_SLOT_PRE) begin
                     state_reg <= PRVD_WAIT_LOW;
                     done_reg  <= 1'b1;
                  end
               end
               PRVD_WAIT_LOW: begin
                  // Past slot 16 the line is ignored until the sync drops
                  if (!fsync_now) begin
                     state_reg <= PRVD_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // Gain code only changes on a complete linear frame
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         gain_code_reg <= `PRVD_GAIN_RESET;
      end else if (done_reg && frm_lin_reg) begin
         gain_code_reg <= shift_reg[2:0];
      end
   end

   always_comb begin
      if (lvl_reg[`PRVD_PIN_MUTE]) begin
         new_sample = 13'h0000;
      end else if (frm_lin_reg) begin
         new_sample = shift_reg[15:3];
      end else begin
         new_sample = {5'h00, shift_reg[15:8]};
      end
      new_gain_db = frm_lin_reg ? gain_db_f(shift_reg[2:0]) : `PRVD_GAIN_0DB;
   end

   // Output stage plus one skid entry; a stalled reader loses nothing for two frames
   assign pop = out_valid_reg & out_ready;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         out_valid_reg    <= 1'b0;
         out_sample_reg   <= 13'h0000;
         out_linear_reg   <= 1'b0;
         out_gain_db_reg  <= `PRVD_GAIN_0DB;
         skid_valid_reg   <= 1'b0;
         skid_sample_reg  <= 13'h0000;
         skid_linear_reg  <= 1'b0;
         skid_gain_db_reg <= `PRVD_GAIN_0DB;
         overrun_reg      <= 1'b0;
      end else begin
         if (!out_valid_reg || pop) begin
            if (skid_valid_reg) begin
               out_valid_reg    <= 1'b1;
               out_sample_reg   <= skid_sample_reg;
               out_linear_reg   <= skid_linear_reg;
               out_gain_db_reg  <= skid_gain_db_reg;
               skid_valid_reg   <= done_reg;
               skid_sample_reg  <= new_sample;
               skid_linear_reg  <= frm_lin_reg;
               skid_gain_db_reg <= new_gain_db;
            end else begin
               out_valid_reg    <= done_reg;
               out_sample_reg   <= new_sample;
               out_linear_reg   <= frm_lin_reg;
               out_gain_db_reg  <= new_gain_db;
            end
         end else if (done_reg) begin
            if (!skid_valid_reg) begin
               skid_valid_reg   <= 1'b1;
               skid_sample_reg  <= new_sample;
               skid_linear_reg  <= frm_lin_reg;
               skid_gain_db_reg <= new_gain_db;
            end else begin
               // Both entries full: the new frame is dropped and flagged
               overrun_reg <= 1'b1;
            end
         end
      end
   end

   assign out_valid    = out_valid_reg;
   assign out_sample   = out_sample_reg;
   assign out_linear   = out_linear_reg;
   assign out_gain_db  = out_gain_db_reg;
   assign rx_gain_code = gain_code_reg;
   assign overrun      = overrun_reg;

   property p_comp_word;
      @(posedge clk_sys) disable iff (!rst_n)
      done_reg && !frm_lin_reg && !lvl_reg[`PRVD_PIN_MUTE] && !out_valid_reg && !skid_valid_reg
      |=> out_valid_reg && out_sample_reg[7:0] == $past(shift_reg[15:8])
          && out_sample_reg[12:8] == 5'h00;
   endproperty
   a_comp_word: assert property (p_comp_word) else $error("companded word mismatch");

   property p_lin_word;
      @(posedge clk_sys) disable iff (!rst_n)
      done_reg && frm_lin_reg && !lvl_reg[`PRVD_PIN_MUTE] && !out_valid_reg && !skid_valid_reg
      |=> out_valid_reg && out_linear_reg && out_sample_reg == $past(shift_reg[15:3]);
   endproperty
   a_lin_word: assert property (p_lin_word) else $error("linear sample mismatch");

   property p_gain_code;
      @(posedge clk_sys) disable iff (!rst_n)
      done_reg && frm_lin_reg |=> gain_code_reg == $past(shift_reg[2:0]);
   endproperty
   a_gain_code: assert property (p_gain_code) else $error("gain code not taken");

   property p_comp_0db;
      @(posedge clk_sys) disable iff (!rst_n)
      done_reg && !frm_lin_reg && !out_valid_reg && !skid_valid_reg
      |=> out_gain_db_reg == 6'h00;
   endproperty
   a_comp_0db: assert property (p_comp_0db) else $error("companded gain not 0 dB");

   property p_gain_step;
      @(posedge clk_sys) disable iff (!rst_n)
      done_reg && frm_lin_reg && !out_valid_reg && !skid_valid_reg
      |=> 8'(signed'(out_gain_db_reg)) + 8'(3 * $past(shift_reg[2:0])) == 8'h03;
   endproperty
   a_gain_step: assert property (p_gain_step) else $error("gain decode wrong");

   property p_silence;
      @(posedge clk_sys) disable iff (!rst_n)
      done_reg && lvl_reg[`PRVD_PIN_MUTE] && !out_valid_reg && !skid_valid_reg
      |=> out_valid_reg && out_sample_reg == 13'h0000;
   endproperty
   a_silence: assert property (p_silence) else $error("muted sample not silent");

   property p_slot_start;
      @(posedge clk_sys) disable iff (!rst_n)
      state_reg == PRVD_IDLE && mclk_fall && fsync_now
      |=> state_reg == PRVD_SHIFT && slot_reg == 5'h01 ##1 !done_reg;
   endproperty
   a_slot_start: assert property (p_slot_start) else $error("slot 1 not started");

   property p_hold_gain;
      @(posedge clk_sys) disable iff (!rst_n)
      done_reg && !frm_lin_reg |=> $stable(gain_code_reg);
   endproperty
   a_hold_gain: assert property (p_hold_gain) else $error("gain changed on companded");

   property p_fall_only;
      @(posedge clk_sys) disable iff (!rst_n)
      !mclk_fall |=> $stable(slot_reg) && !done_reg;
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("slot moved without edge");
endmodule

`default_nettype wire

// ---- verif/prvd_host_model.sv ----
// Host model: free master clock, frame sync and serial receive data
`timescale 1ns/100ps
`default_nettype none
module prvd_host_model (
   input  wire logic [15:0] word,
   output logic             master_clock,
   output logic             frame_sync,
   output logic             serial_rx_data_in,
   output logic [7:0]       slot_cnt
);
   logic        mclk_reg;
   logic        sync_reg  = 1'b0;
   logic        data_reg  = 1'b0;
   logic [7:0]  cnt_reg   = 8'h00;
   logic [15:0] frame_reg = 16'h0000;
   assign master_clock      = mclk_reg;
   assign frame_sync        = sync_reg;
   assign serial_rx_data_in = data_reg;
   assign slot_cnt          = cnt_reg;
   initial begin
      mclk_reg = 1'b0;
      forever #244 mclk_reg = ~mclk_reg;
   end
   // Launch on the rise, half a period before the capturing fall
   always @(posedge mclk_reg) begin
      cnt_reg <= cnt_reg + 8'h01;
      sync_reg <= (cnt_reg == 8'hff);
      if (cnt_reg == 8'hff) begin
         frame_reg <= word;
         data_reg <= word[15];
      end else if (cnt_reg < 8'h0f) begin
         data_reg <= frame_reg[4'he - cnt_reg[3:0]];
      end else begin
         // Toggle when idle so a stale bit is never mistaken for data
         data_reg <= ~data_reg;
      end
   end
endmodule
`default_nettype wire

// ---- verif/prvd_rx_deframer_tb.sv ----
// Self-checking bench for the receive deframer
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module prvd_rx_deframer_tb;
   import prvd_pkg::*;
   logic            clk_sys, rst_n, linear_select, earpiece_silence, out_ready;
   logic            out_valid, out_linear, overrun;
   logic            master_clock, frame_sync, serial_rx_data_in;
   logic [15:0]     word;
   logic [7:0]      slot_cnt;
   prvd_sample_t    out_sample;
   prvd_gain_db_t   out_gain_db;
   prvd_gain_code_t rx_gain_code;
   int              n_mismatch = 0;
   int              total_checks = 0;
   int              cycles = 0;

   prvd_host_model host (.word(word), .master_clock(master_clock), .frame_sync(frame_sync),
      .serial_rx_data_in(serial_rx_data_in), .slot_cnt(slot_cnt));
   prvd_rx_deframer uut (.clk_sys(clk_sys), .rst_n(rst_n), .master_clock(master_clock),
      .frame_sync(frame_sync), .serial_rx_data_in(serial_rx_data_in),
      .linear_select(linear_select), .earpiece_silence(earpiece_silence),
      .out_ready(out_ready), .out_valid(out_valid), .out_sample(out_sample),
      .out_linear(out_linear), .out_gain_db(out_gain_db), .rx_gain_code(rx_gain_code),
      .overrun(overrun));

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic wait_slot(input logic [7:0] n);
      for (int i = 0; i < 6000 && slot_cnt !== n; i++) @(negedge clk_sys);
   endtask

   // Mode and mute set mid-gap, held until the next frame is pushed
   task automatic send(input logic lin, input logic mute, input logic [15:0] w);
      wait_slot(8'h80);
      linear_select = ~lin;
      earpiece_silence = mute;
      word = w;
      wait_slot(8'h20);
   endtask

   task automatic take(input prvd_sample_t s, input logic lin, input prvd_gain_db_t db);
      // One edge apart, so back-to-back takes never drive out_ready twice at once
      @(negedge clk_sys);
      for (int i = 0; i < 200 && out_valid !== 1'b1; i++) @(negedge clk_sys);
      `CHK("out_valid", 1'b1, out_valid)
      `CHK("out_sample", s, out_sample)
      `CHK("out_linear", lin, out_linear)
      `CHK("out_gain_db", db, out_gain_db)
      out_ready = 1'b1;
      @(negedge clk_sys);
      out_ready = 1'b0;
   endtask

   task automatic test_linear();
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         send(1'b1, 1'b0, {{c, 10'h2a5} ^ 13'h1001, c});
         take({c, 10'h2a5} ^ 13'h1001, 1'b1, 6'(3 - 3 * i));
         `CHK("rx_gain_code", c, rx_gain_code)
      end
      `CHK("out_valid", 1'b0, out_valid)
      $display("test linear done");
   endtask

   task automatic test_compand();
      send(1'b0, 1'b0, 16'ha53c);
      take({5'h00, 8'ha5}, 1'b0, 6'h00);
      `CHK("rx_gain_code", 3'h7, rx_gain_code)
      $display("test companded done");
   endtask

   task automatic test_mute();
      send(1'b1, 1'b1, {13'h1fff, 3'h2});
      take(13'h0000, 1'b1, 6'h3d);
      `CHK("rx_gain_code", 3'h2, rx_gain_code)
      earpiece_silence = 1'b0;
      $display("test mute done");
   endtask

   task automatic test_stall();
      send(1'b1, 1'b0, {13'h0123, 3'h3});
      send(1'b1, 1'b0, {13'h1edc, 3'h4});
      `CHK("overrun", 1'b0, overrun)
      send(1'b1, 1'b0, {13'h0777, 3'h5});
      `CHK("overrun", 1'b1, overrun)
      take(13'h0123, 1'b1, 6'h3a);
      take(13'h1edc, 1'b1, 6'h37);
      `CHK("out_valid", 1'b0, out_valid)
      $display("test stall done");
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         test_done();
      end
   end

   initial begin
      {rst_n, linear_select, earpiece_silence, out_ready} = 4'h0;
      word = 16'h0000;
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      `CHK("out_valid", 1'b0, out_valid)
      `CHK("rx_gain_code", 3'h1, rx_gain_code)
      `CHK("out_gain_db", 6'h00, out_gain_db)
      `CHK("overrun", 1'b0, overrun)
      test_linear();
      test_compand();
      test_mute();
      test_stall();
      test_done();
   end
endmodule
`default_nettype wire
